// ===== src/pmc_pkg.sv
// Constants and types of the power mode controller
package pmc_pkg;
   // ==========================================================
   // Register byte offsets
   localparam logic [3:0] PMC_PLL_OFS  = 4'h0;
   localparam logic [3:0] PMC_VREG_OFS = 4'h4;
   localparam logic [3:0] PMC_CMD_OFS  = 4'h8;
   localparam logic [3:0] PMC_STAT_OFS = 4'hc;
   // ==========================================================
   // Field positions and reset values
   localparam int         PMC_OFF_BIT  = 0;
   localparam int         PMC_BYP_BIT  = 1;
   localparam int         PMC_MUL_LSB  = 8;
   localparam int         PMC_MUL_W    = 6;
   localparam logic [5:0] PMC_MUL_RST  = 6'h0a;
   localparam logic [1:0] PMC_REGULATOR_FREQUENCY_FIELD_RST = 2'h3;
   localparam logic [1:0] PMC_REGULATOR_FREQUENCY_FIELD_HIB = 2'h0;
   localparam logic [7:0] PMC_EN_RST   = 8'heb;
   // ==========================================================
   // Mode commands
   localparam logic [1:0] PMC_CMD_GO    = 2'h0;
   localparam logic [1:0] PMC_CMD_SLEEP = 2'h1;
   localparam logic [1:0] PMC_CMD_DEEP  = 2'h2;
   // ==========================================================
   // Modes
   typedef enum logic [2:0] {
      PMC_FULL_ON, PMC_ACTIVE, PMC_SLEEP, PMC_DEEP, PMC_HIB, PMC_BOOT
   } pmc_mode_e;
endpackage

// ===== src/pmc_power_mode_controller.sv
// Power mode controller with Avalon-MM register slave
`timescale 1ns/10ps
// Contract
// - After reset enter full-on: PLL enabled, not bypassed, clocks at full speed.
// - Active mode bypasses the PLL, enabled unless its off bit is written; clocks at input clock rate.
// - Multiplier written in active mode waits pending until full-on entered.
// - Active mode allows DMA into level-one memory.
// - Sleep stops core clock; PLL and system clock keep running.
// - Sleep wake goes full-on if bypass clear, active if set.
// - Sleep mode refuses system DMA into level-one memory.
// - CAN wake-up event ends sleep.
// - Deep sleep stops core clock and system clock.
// - Deep sleep denies async peripherals internal and external access.
// - Deep sleep exits only on reset or RTC interrupt.
// - RTC interrupt in deep sleep moves to active mode.
// - Reset during deep sleep resets and enters full-on.
// - Frequency field write of 00 enters hibernate, regulator and clocks off.
// - Hibernate places external pins in high impedance.
// - Hibernate wakes on RTC, CAN, reset or external source.
// - Every wake from hibernate except reset starts the boot sequence; reset goes straight to full-on.
module pmc_power_mode_controller
   import pmc_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        reset_n_in,
   input  wire logic [3:0]  address_in,
   input  wire logic        read_in,
   input  wire logic        write_in,
   input  wire logic [31:0] writedata_in,
   output logic      [31:0] readdata_out,
   output logic             waitrequest_out,
   input  wire logic        wake_rtc_in,
   input  wire logic        wake_can_in,
   input  wire logic        wake_ext_in,
   output logic             core_clk_en_out,
   output logic             sys_clk_en_out,
   output logic             pll_en_out,
   output logic             pll_bypass_out,
   output logic [5:0]       pll_mult_out,
   output logic             regulator_on_out,
   output logic             pins_hiz_out,
   output logic             dma_l1_en_out,
   output logic             async_access_en_out,
   output logic             boot_start_out,
   output logic [2:0]       mode_out
);
   // ==========================================================
   // State
   typedef struct packed {
      pmc_mode_e   mode;
      logic        pll_off;
      logic        bypass;
      logic [5:0]  mult_pend;
      logic [5:0]  mult;
      logic [1:0]  regulator_frequency_field;
      logic        wait_r;
      logic [31:0] rdata;
      logic        boot;
      logic [7:0]  en;
   } pmc_state_s;

   pmc_state_s s;
   pmc_state_s next_s;
   logic       acc;
   logic       wr;
   logic       any_wake;

   // Enables: core_clock sclk pll byp vreg hiz dma async
   function automatic logic [7:0] pmc_enables(pmc_mode_e m, logic off);
      case (m)
         PMC_FULL_ON: pmc_enables = 8'heb;
         PMC_ACTIVE:  pmc_enables = {2'h3, ~off, 5'h1b};
         PMC_SLEEP:   pmc_enables = 8'h69;
         PMC_DEEP:    pmc_enables = 8'h08;
         PMC_HIB:     pmc_enables = 8'h04;
         default:     pmc_enables = 8'h08;
      endcase
   endfunction

   // Core clock running: only then do software writes take effect
   function automatic logic pmc_core_runs(pmc_mode_e m);
      pmc_core_runs = (m == PMC_FULL_ON) || (m == PMC_ACTIVE);
   endfunction

   // ==========================================================
   // Next state
   assign acc = (read_in | write_in) & ~s.wait_r;
   assign wr  = acc & write_in;
   assign any_wake = wake_rtc_in | wake_can_in | wake_ext_in;

   always_comb begin
      next_s = s;
      next_s.boot = 1'b0;
      // Answer one cycle after the request is seen
      next_s.wait_r = ~((read_in | write_in) & s.wait_r);
      if ((read_in | write_in) & s.wait_r) begin
         case (address_in)
            PMC_PLL_OFS: next_s.rdata = {18'h0, s.mult_pend, 6'h0, s.bypass, s.pll_off};
            PMC_VREG_OFS: next_s.rdata = {30'h0, s.regulator_frequency_field};
            PMC_STAT_OFS: next_s.rdata = {18'h0, s.mult, 5'h0, s.mode};
            default: next_s.rdata = 32'h0;
         endcase
      end
      // Software acts only while the core runs
      if (wr && pmc_core_runs(s.mode)) begin
         case (address_in)
            PMC_PLL_OFS: begin
               next_s.pll_off   = writedata_in[PMC_OFF_BIT] & (s.mode == PMC_ACTIVE);
               next_s.bypass    = writedata_in[PMC_BYP_BIT];
               next_s.mult_pend = writedata_in[PMC_MUL_LSB +: PMC_MUL_W];
            end
            PMC_VREG_OFS: begin
               next_s.regulator_frequency_field = writedata_in[1:0];
               if (writedata_in[1:0] == PMC_REGULATOR_FREQUENCY_FIELD_HIB) begin
                  next_s.mode = PMC_HIB;
               end
            end
            PMC_CMD_OFS: begin
               // A disabled PLL blocks full-on and sleep requests
               if (writedata_in[1:0] == PMC_CMD_GO && !s.pll_off) begin
                  next_s.mode = s.bypass ? PMC_ACTIVE : PMC_FULL_ON;
               end else if (writedata_in[1:0] == PMC_CMD_SLEEP && !s.pll_off) begin
                  next_s.mode = PMC_SLEEP;
               end else if (writedata_in[1:0] == PMC_CMD_DEEP) begin
                  next_s.mode = PMC_DEEP;
               end
            end
            default: ;
         endcase
      end
      // Wake sources
      case (s.mode)
         PMC_SLEEP: begin
            if (any_wake) begin
               next_s.mode = s.bypass ? PMC_ACTIVE : PMC_FULL_ON;
            end
         end
         PMC_DEEP: begin
            if (wake_rtc_in) begin
               next_s.mode = PMC_ACTIVE;
            end
         end
         PMC_HIB: begin
            if (any_wake) begin
               next_s.mode = PMC_BOOT;
               next_s.boot = 1'b1;
               next_s.regulator_frequency_field = PMC_REGULATOR_FREQUENCY_FIELD_RST;
            end
         end
         PMC_BOOT: begin
            next_s.mode    = PMC_FULL_ON;
            next_s.pll_off = 1'b0;
            next_s.bypass  = 1'b0;
         end
         default: ;
      endcase
      // Pending multiplier lands whenever the next mode is full-on
      if (next_s.mode == PMC_FULL_ON) begin
         next_s.mult = next_s.mult_pend;
      end
      next_s.en = pmc_enables(next_s.mode, next_s.pll_off);
   end

   // ==========================================================
   // Registers; reset from any mode lands in full-on
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         s           <= '0;
         s.mode      <= PMC_FULL_ON;
         s.mult_pend <= PMC_MUL_RST;
         s.mult      <= PMC_MUL_RST;
         s.regulator_frequency_field      <= PMC_REGULATOR_FREQUENCY_FIELD_RST;
         s.wait_r    <= 1'b1;
         s.en        <= PMC_EN_RST;
      end else begin
         s <= next_s;
      end
   end

   assign readdata_out        = s.rdata;
   assign waitrequest_out     = s.wait_r;
   assign core_clk_en_out     = s.en[7];
   assign sys_clk_en_out      = s.en[6];
   assign pll_en_out          = s.en[5];
   assign pll_bypass_out      = s.en[4];
   assign regulator_on_out    = s.en[3];
   assign pins_hiz_out        = s.en[2];
   assign dma_l1_en_out       = s.en[1];
   assign async_access_en_out = s.en[0];
   assign pll_mult_out        = s.mult;
   assign boot_start_out      = s.boot;
   assign mode_out            = s.mode;

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);

   chk_full_on_clocks: assert property (
      mode_out == PMC_FULL_ON |-> core_clk_en_out && pll_en_out && !pll_bypass_out)
      else $error("full-on clocks wrong");
   chk_active_bypass: assert property (
      mode_out == PMC_ACTIVE |-> pll_bypass_out && sys_clk_en_out && dma_l1_en_out)
      else $error("active mode bypass wrong");
   chk_mult_pending: assert property (
      mode_out == PMC_ACTIVE && $past(mode_out) == PMC_ACTIVE |-> $stable(pll_mult_out))
      else $error("multiplier changed in active");
   chk_sleep_clocks: assert property (
      mode_out == PMC_SLEEP |-> !core_clk_en_out && sys_clk_en_out && !dma_l1_en_out)
      else $error("sleep clocks wrong");
   chk_sleep_wake: assert property (
      mode_out == PMC_SLEEP && wake_can_in |=>
         mode_out == ($past(s.bypass) ? PMC_ACTIVE : PMC_FULL_ON))
      else $error("sleep wake target wrong");
   chk_deep_hold: assert property (
      mode_out == PMC_DEEP && !wake_rtc_in |=> mode_out == PMC_DEEP)
      else $error("deep sleep left without rtc");
   chk_deep_rtc: assert property (
      mode_out == PMC_DEEP && wake_rtc_in |=> mode_out == PMC_ACTIVE && sys_clk_en_out)
      else $error("rtc did not reach active");
   chk_deep_clocks: assert property (
      mode_out == PMC_DEEP |-> !core_clk_en_out && !sys_clk_en_out && !async_access_en_out)
      else $error("deep sleep clocks wrong");
   chk_hib_entry: assert property (
      wr && address_in == PMC_VREG_OFS && writedata_in[1:0] == PMC_REGULATOR_FREQUENCY_FIELD_HIB
      && mode_out == PMC_FULL_ON |=> !regulator_on_out && pins_hiz_out)
      else $error("hibernate not entered");
   chk_hib_boot: assert property (
      mode_out == PMC_HIB && wake_ext_in |=> boot_start_out ##1 mode_out == PMC_FULL_ON)
      else $error("boot not started");
   chk_bus_answer: assert property (
      (read_in || write_in) && waitrequest_out |=> !waitrequest_out ##1 waitrequest_out)
      else $error("bus answer timing wrong");

   // ==========================================================
   // Bus checks
   chk_bus_idle_wait: assert property (
      !read_in && !write_in |=> waitrequest_out)
      else $error("waitrequest low without request");
   chk_stat_mode: assert property (
      read_in && waitrequest_out && address_in == PMC_STAT_OFS
      |=> readdata_out[2:0] == $past(mode_out))
      else $error("status mode readback wrong");
   chk_cmd_reads_zero: assert property (
      read_in && waitrequest_out && address_in == PMC_CMD_OFS |=> readdata_out == 32'h0)
      else $error("command register read not zero");
   // Stopped core: write still answered so the master never hangs
   chk_write_refused: assert property (
      wr && !pmc_core_runs(s.mode) && s.mode != PMC_BOOT && !any_wake
      |=> $stable(mode_out) && $stable(s.regulator_frequency_field) && $stable(s.mult_pend))
      else $error("write landed while core stopped");

   // ==========================================================
   // Mode checks
   chk_dma_gate: assert property (
      dma_l1_en_out == pmc_core_runs(s.mode))
      else $error("dma gate wrong for mode");
   chk_async_gate: assert property (
      async_access_en_out |-> regulator_on_out && mode_out != PMC_DEEP)
      else $error("async access granted while stopped");
   chk_hib_pins: assert property (
      pins_hiz_out == (mode_out == PMC_HIB))
      else $error("pin release wrong for mode");
   chk_regulator_off: assert property (
      regulator_on_out == (mode_out != PMC_HIB))
      else $error("regulator state wrong for mode");
   chk_bypass_active: assert property (
      pll_bypass_out |-> mode_out == PMC_ACTIVE)
      else $error("bypass outside active mode");
   chk_mult_full_on: assert property (
      mode_out == PMC_FULL_ON |-> pll_mult_out == s.mult_pend)
      else $error("pending multiplier not applied");
   chk_pll_off_block: assert property (
      wr && s.mode == PMC_ACTIVE && s.pll_off && address_in == PMC_CMD_OFS
      && writedata_in[1:0] != PMC_CMD_DEEP |=> mode_out == PMC_ACTIVE)
      else $error("command taken with pll off");
   chk_go_target: assert property (
      wr && pmc_core_runs(s.mode) && address_in == PMC_CMD_OFS
      && writedata_in[1:0] == PMC_CMD_GO && !s.pll_off
      |=> mode_out == ($past(s.bypass) ? PMC_ACTIVE : PMC_FULL_ON))
      else $error("go command target wrong");
   chk_deep_cmd: assert property (
      wr && pmc_core_runs(s.mode) && address_in == PMC_CMD_OFS
      && writedata_in[1:0] == PMC_CMD_DEEP |=> mode_out == PMC_DEEP)
      else $error("deep sleep command not taken");

   // ==========================================================
   // Wake checks
   chk_sleep_hold: assert property (
      mode_out == PMC_SLEEP && !any_wake |=> mode_out == PMC_SLEEP)
      else $error("sleep left without wake");
   chk_sleep_any: assert property (
      mode_out == PMC_SLEEP && any_wake
      |=> mode_out == PMC_ACTIVE || mode_out == PMC_FULL_ON)
      else $error("wake did not end sleep");
   chk_hib_wake: assert property (
      mode_out == PMC_HIB && any_wake |=> mode_out == PMC_BOOT && regulator_on_out)
      else $error("hibernate wake not taken");
   chk_hib_hold: assert property (
      mode_out == PMC_HIB && !any_wake |=> mode_out == PMC_HIB)
      else $error("hibernate left without wake");
   chk_boot_once: assert property (
      mode_out == PMC_BOOT
      |=> mode_out == PMC_FULL_ON && !boot_start_out && !pll_bypass_out)
      else $error("boot did not end in full-on");

   cov_sleep_wake: cover property (mode_out == PMC_SLEEP ##1 mode_out == PMC_FULL_ON);
   cov_deep_rtc: cover property (mode_out == PMC_DEEP ##1 mode_out == PMC_ACTIVE);
   cov_hib_boot: cover property (mode_out == PMC_HIB ##1 boot_start_out);
   cov_active_entry: cover property (mode_out == PMC_FULL_ON ##1 mode_out == PMC_ACTIVE);
   cov_go_refused: cover property (wr && s.pll_off && address_in == PMC_CMD_OFS);
endmodule

// ===== tb/pmc_wake_model.sv
// Wake source model: one-cycle wake pulses on request
`timescale 1ns/10ps
module pmc_wake_model (
   input  wire logic       clk_in,
   input  wire logic [2:0] fire_in,
   output logic            wake_rtc_out = 1'b0,
   output logic            wake_can_out = 1'b0,
   output logic            wake_ext_out = 1'b0
);
   // ==========================================
   // Pulses
   // Sources idle low; registered so edges never race the controller
   always @(posedge clk_in) begin
      {wake_ext_out, wake_can_out, wake_rtc_out} <= fire_in;
   end
endmodule

// ===== tb/pmc_power_mode_controller_tb_top.sv
// Testbench of the power mode controller
`timescale 1ns/10ps
module pmc_power_mode_controller_tb_top
   import pmc_pkg::*;
;
   // ==========================================
   // Signals
   logic        clk_in = 1'b0, reset_n_in = 1'b0, read_in = 1'b0, write_in = 1'b0;
   logic [3:0]  address_in = 4'h0;
   logic [31:0] writedata_in = 32'h0, readdata, rd;
   logic [2:0]  fire = 3'h0, mode;
   logic [5:0]  mult;
   logic        w_rtc, w_can, w_ext, waitreq, core_en, sys_en, pll_en, byp, reg_on, hiz;
   logic        dma, asy, boot;
   int          bad_count = 0, cmp_count = 0, cyc = 0, i;
   always #10 clk_in = ~clk_in;
   pmc_power_mode_controller DUT (.clk_in(clk_in), .reset_n_in(reset_n_in),
      .address_in(address_in), .read_in(read_in), .write_in(write_in),
      .writedata_in(writedata_in), .readdata_out(readdata), .waitrequest_out(waitreq),
      .wake_rtc_in(w_rtc), .wake_can_in(w_can), .wake_ext_in(w_ext),
      .core_clk_en_out(core_en), .sys_clk_en_out(sys_en), .pll_en_out(pll_en),
      .pll_bypass_out(byp), .pll_mult_out(mult), .regulator_on_out(reg_on),
      .pins_hiz_out(hiz), .dma_l1_en_out(dma), .async_access_en_out(asy),
      .boot_start_out(boot), .mode_out(mode));
   pmc_wake_model wake (.clk_in(clk_in), .fire_in(fire), .wake_rtc_out(w_rtc),
      .wake_can_out(w_can), .wake_ext_out(w_ext));
   // ==========================================
   // Tasks
   task automatic end_sim;
      $display("Comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Request held until waitrequest seen low at a rising edge
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_in);
      address_in   <= a;
      writedata_in <= d;
      read_in      <= !wr;
      write_in     <= wr;
      do @(posedge clk_in); while (waitreq !== 1'b0);
      rd = readdata;
      read_in  <= 1'b0;
      write_in <= 1'b0;
   endtask
   // Bounded wait, then compare the mode
   task automatic wait_mode(input logic [2:0] m);
      int n;
      n = 0;
      do begin
         @(posedge clk_in);
         #1;
         n++;
      end while (mode !== m && n < 8);
      chk(32'(mode), 32'(m));
   endtask
   task automatic pulse(input logic [2:0] s);
      @(posedge clk_in);
      fire <= s;
      @(posedge clk_in);
      fire <= 3'h0;
   endtask
   task automatic do_reset;
      @(posedge clk_in) reset_n_in <= 1'b0;
      @(posedge clk_in) reset_n_in <= 1'b1;
      #1;
   endtask
   // ==========================================
   // Timeout
   always @(posedge clk_in) begin
      cyc++;
      if (cyc > 3000) begin
         bad_count++;
         end_sim();
      end
   end
   // ==========================================
   // Tests
   initial begin
      repeat (4) @(posedge clk_in);
      reset_n_in <= 1'b1;
      #1;
      chk({core_en, sys_en, pll_en, byp, reg_on, hiz}, 32'h3a);
      bus(1'b0, PMC_STAT_OFS, 32'h0);
      chk(rd, 32'h0a00);
      bus(1'b0, 4'h2, 32'h0);
      chk(rd, 32'h0);
      bus(1'b1, PMC_PLL_OFS, 32'h0a02);
      bus(1'b1, PMC_CMD_OFS, {30'h0, PMC_CMD_GO});
      wait_mode(PMC_ACTIVE);
      chk({pll_en, byp, core_en, sys_en, dma}, 32'h1f);
      // Pending multiplier, PLL off blocks go
      bus(1'b1, PMC_PLL_OFS, 32'h1003);
      bus(1'b1, PMC_CMD_OFS, {30'h0, PMC_CMD_GO});
      repeat (3) @(posedge clk_in);
      chk({mode, mult}, {3'h1, 6'h0a});
      bus(1'b1, PMC_CMD_OFS, {30'h0, PMC_CMD_SLEEP});
      repeat (3) @(posedge clk_in);
      chk({mode, pll_en}, {3'h1, 1'b0});
      bus(1'b0, PMC_PLL_OFS, 32'h0);
      chk(rd, 32'h1003);
      bus(1'b0, PMC_STAT_OFS, 32'h0);
      chk(rd, 32'h0a01);
      bus(1'b1, PMC_PLL_OFS, 32'h1000);
      bus(1'b1, PMC_CMD_OFS, {30'h0, PMC_CMD_GO});
      wait_mode(PMC_FULL_ON);
      repeat (2) @(posedge clk_in);
      chk(32'(mult), 32'h10);
      for (i = 0; i < 3; i++) begin
         bus(1'b1, PMC_PLL_OFS, {18'h0, 6'h10, 6'h0, i[0], 1'b0});
         bus(1'b1, PMC_CMD_OFS, {30'h0, PMC_CMD_SLEEP});
         wait_mode(PMC_SLEEP);
         chk({core_en, sys_en, pll_en, dma}, 32'h6);
         bus(1'b0, PMC_STAT_OFS, 32'h0);
         chk(rd, 32'h1002);
         bus(1'b1, PMC_VREG_OFS, {30'h0, PMC_REGULATOR_FREQUENCY_FIELD_HIB});
         repeat (2) @(posedge clk_in);
         chk(32'(mode), 32'(PMC_SLEEP));
         pulse(3'h1 << i);
         wait_mode(i[0] ? PMC_ACTIVE : PMC_FULL_ON);
         bus(1'b1, PMC_PLL_OFS, 32'h1000);
         bus(1'b1, PMC_CMD_OFS, {30'h0, PMC_CMD_GO});
         wait_mode(PMC_FULL_ON);
      end
      bus(1'b1, PMC_CMD_OFS, {30'h0, PMC_CMD_DEEP});
      wait_mode(PMC_DEEP);
      chk({core_en, sys_en, asy}, 32'h0);
      bus(1'b0, PMC_STAT_OFS, 32'h0);
      chk(rd, 32'h1003);
      pulse(3'h6);
      repeat (3) @(posedge clk_in);
      chk(32'(mode), 32'(PMC_DEEP));
      pulse(3'h1);
      wait_mode(PMC_ACTIVE);
      bus(1'b1, PMC_CMD_OFS, {30'h0, PMC_CMD_DEEP});
      wait_mode(PMC_DEEP);
      do_reset();
      chk(32'(mode), 32'(PMC_FULL_ON));
      for (i = 0; i < 4; i++) begin
         bus(1'b1, PMC_VREG_OFS, {30'h0, PMC_REGULATOR_FREQUENCY_FIELD_HIB});
         wait_mode(PMC_HIB);
         chk({reg_on, hiz, core_en, sys_en}, 32'h4);
         bus(1'b0, PMC_STAT_OFS, 32'h0);
         chk(rd, 32'h0a04);
         if (i < 3) begin
            pulse(3'h1 << i);
            wait_mode(PMC_BOOT);
            chk({boot, reg_on, hiz}, 32'h6);
            wait_mode(PMC_FULL_ON);
            chk({boot, core_en, sys_en}, 32'h3);
            bus(1'b0, PMC_VREG_OFS, 32'h0);
            chk(rd, 32'h3);
         end else begin
            do_reset();
            chk({mode, reg_on, hiz}, 32'h2);
         end
      end
      end_sim();
   end
endmodule
